/* File: verilog/ecs_pkg.sv */
package ecs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register word offsets (byte address = index * 4)
   localparam logic [3:0] ecs_idx_divider      = 4'h0;
   localparam logic [3:0] ecs_idx_config       = 4'h3;
   localparam logic [3:0] ecs_idx_protect      = 4'h4;
   localparam logic [3:0] ecs_idx_status       = 4'h5;
   localparam logic [3:0] ecs_idx_command      = 4'h6;
   localparam logic [3:0] ecs_idx_test_three   = 4'h7;
   localparam logic [3:0] ecs_idx_addr_high    = 4'h8;
   localparam logic [3:0] ecs_idx_addr_low     = 4'h9;
   localparam logic [3:0] ecs_idx_data_high    = 4'ha;
   localparam logic [3:0] ecs_idx_data_low     = 4'hb;
   // array write window and control port
   localparam logic [3:0] ecs_idx_array_addr   = 4'hc;
   localparam logic [3:0] ecs_idx_array_data   = 4'hd;
   localparam logic [3:0] ecs_idx_control      = 4'he;

   ////////////////////////////////////////////////////////////////////////////////
   // status, divider, config and control bit positions
   localparam int ecs_bit_buffer_empty  = 7;
   localparam int ecs_bit_complete      = 6;
   localparam int ecs_bit_violation     = 5;
   localparam int ecs_bit_access_error  = 4;
   localparam int ecs_bit_blank         = 2;
   localparam int ecs_bit_divider_load  = 7;
   localparam int ecs_bit_be_irq_enable = 7;
   localparam int ecs_bit_cc_irq_enable = 6;
   localparam int ecs_bit_special_mode  = 0;
   localparam int ecs_bit_stop_request  = 1;

   localparam logic [7:0] ecs_command_mask  = 8'h65;
   localparam logic [7:0] ecs_addr_high_mask = 8'h07;
   localparam logic [7:0] ecs_divider_mask  = 8'h7f;

   ////////////////////////////////////////////////////////////////////////////////
   // command codes
   localparam logic [7:0] ecs_cmd_erase_verify  = 8'h05;
   localparam logic [7:0] ecs_cmd_word_program  = 8'h20;
   localparam logic [7:0] ecs_cmd_sector_erase  = 8'h40;
   localparam logic [7:0] ecs_cmd_mass_erase    = 8'h41;
   localparam logic [7:0] ecs_cmd_sector_modify = 8'h60;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values and timing
   localparam logic [7:0]  ecs_status_reset  = 8'hc0;
   localparam logic [15:0] ecs_exec_ticks    = 16'h0004;
   localparam int          ecs_array_words   = 1024;

   typedef enum logic [1:0] {ecs_seq_idle, ecs_seq_have_word, ecs_seq_have_cmd} ecs_seq_type;

   typedef struct packed {
      logic [7:0]  code;
      logic [10:0] addr;
      logic [15:0] data;
   } ecs_job_type;

   typedef struct packed {
      logic [6:0] ratio;
      logic       start;
   } ecs_tick_cfg_type;

endpackage : ecs_pkg

/* File: verilog/ecs_timebase.sv */
`timescale 1ns/1ns
// divides pclk into one-cycle ticks of the sequencer timebase
module ecs_timebase
   import ecs_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire ecs_tick_cfg_type cfg,
   output logic                  tick
);
   typedef struct packed {
      logic [9:0] count;
      logic       tick;
   } ecs_tb_state_type;

   ecs_tb_state_type st;
   ecs_tb_state_type next_st;
   logic [9:0]       limit;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      limit   = {cfg.ratio[6] ? {cfg.ratio[5:0], 3'b111} : {3'b000, cfg.ratio[5:0]}, 1'b1};
      next_st = st;
      next_st.tick = 1'b0;
      if (!cfg.start) begin
         next_st.count = '0;
      end else if (st.count >= limit) begin
         next_st.count = '0;
         next_st.tick  = 1'b1;
      end else begin
         next_st.count = st.count + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule : ecs_timebase

/* File: verilog/ecs_array.sv */
`timescale 1ns/1ns
// the array itself: executes one job at a time in timebase ticks
module ecs_array
   import ecs_pkg::*;
#(
   parameter int WORDS = ecs_array_words
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tick,
   input  wire logic        start,
   input  wire logic        abort,
   input  wire ecs_job_type job,
   output logic             busy,
   output logic             done,
   output logic             blank
);
   typedef struct packed {
      logic        busy;
      logic        done;
      logic        blank;
      logic [15:0] ticks;
      ecs_job_type job;
   } ecs_arr_state_type;

   ecs_arr_state_type st;
   ecs_arr_state_type next_st;
   logic [15:0]       mem [WORDS];
   logic [WORDS-1:0]  erased;
   logic              mem_we;
   logic [9:0]        waddr;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      mem_we       = 1'b0;
      waddr        = st.job.addr[10:1];
      if (abort) begin
         next_st.busy = 1'b0;
      end else if (start && !st.busy) begin
         next_st.busy  = 1'b1;
         next_st.ticks = ecs_exec_ticks;
         next_st.job   = job;
      end else if (st.busy && tick) begin
         if (st.ticks == 16'h0001) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            next_st.blank = (st.job.code == ecs_cmd_erase_verify) && (&erased);
            mem_we = (st.job.code == ecs_cmd_word_program)
                  || (st.job.code == ecs_cmd_sector_modify);
         end else begin
            next_st.ticks = st.ticks - 16'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st     <= '0;
         erased <= '1;
      end else begin
         st <= next_st;
         if (st.busy && tick && st.ticks == 16'h0001) begin
            if (st.job.code == ecs_cmd_mass_erase) erased <= '1;
            if (st.job.code == ecs_cmd_sector_erase || st.job.code == ecs_cmd_sector_modify)
               erased[{waddr[9:1], 1'b0} +: 2] <= 2'b11;
         end
         // sector modify re-programs one word after erasing the pair, so this wins
         if (mem_we) begin
            erased[waddr] <= (st.job.data == 16'hffff);
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[waddr] <= st.job.data;
      end
   end

   assign busy  = st.busy;
   assign done  = st.done;
   assign blank = st.blank;
endmodule : ecs_array

/* File: verilog/ecs_sequencer.sv */
`timescale 1ns/1ns
// How it works
// - writing one clears buffer empty
// - complete clears on launch, sets when idle
// - no complete pulse between chained commands
// - two interrupt requests gated by enables
// - violation on protected address, write-one clears
// - errors lock out command launch
// - access error on sequence, code, stop
// - access error cleared by writing one
// - blank from erase verify, cleared on launch
// - status bit access and zero bits
// - command bits 7,4,3,1 read zero
// - five legal command codes only
// - address registers special mode only
// - sector erase ignores low address bits
// - data registers special mode only
// - two-stage command queue
// - divider write sets loaded, gates commands
// - launch clears complete, buffer refills
// - zero to buffer empty aborts sequence
// - stop aborts active, drops pending
module ecs_sequencer
   import ecs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [5:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             buffer_empty_irq,
   output logic             complete_irq
);
   typedef struct packed {
      ecs_seq_type  seq;
      logic         buffer_empty_flag;
      logic         command_complete_flag;
      logic         protection_violation_flag;
      logic         access_error_flag;
      logic         blank;
      logic         divider_loaded_flag;
      logic [6:0]   divider;
      logic         buffer_empty_irq_enable;
      logic         complete_irq_enable;
      logic [7:0]   protect;
      logic         special_mode;
      logic         stop;
      logic         pending;
      ecs_job_type  stage;
      ecs_job_type  queued;
      logic [31:0]  rdata;
   } ecs_state_type;

   ecs_state_type st;
   ecs_state_type next_st;
   logic          tick;
   logic          arr_busy;
   logic          arr_done;
   logic          arr_blank;
   logic          arr_start;
   logic          arr_abort;
   logic          wr;
   logic          rd;
   logic [3:0]    idx;
   logic [7:0]    wb;

   function automatic logic legal_code(input logic [7:0] c);
      return c == ecs_cmd_erase_verify || c == ecs_cmd_word_program
          || c == ecs_cmd_sector_erase || c == ecs_cmd_mass_erase
          || c == ecs_cmd_sector_modify;
   endfunction : legal_code

   // protected sector lies at the top of the array
   function automatic logic is_protected(input logic [7:0] p, input logic [10:0] a,
                                         input logic [7:0] c);
      logic [11:0] base;
      base = 12'hfc0 - {3'b000, p[2:0], 6'h00};
      if (c == ecs_cmd_erase_verify) return 1'b0;
      if (!p[7]) return 1'b1;
      if (c == ecs_cmd_mass_erase) return !p[3];
      return !p[3] && ({1'b1, a} >= base);
   endfunction : is_protected

   ////////////////////////////////////////////////////////////////////////////////
   ecs_timebase u_timebase (
      .pclk    (pclk),
      .presetn (presetn),
      .cfg     (ecs_tick_cfg_type'{ratio: st.divider, start: st.divider_loaded_flag}),
      .tick    (tick)
   );

   ecs_array u_array (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .start   (arr_start),
      .abort   (arr_abort),
      .job     (st.queued),
      .busy    (arr_busy),
      .done    (arr_done),
      .blank   (arr_blank)
   );

   ////////////////////////////////////////////////////////////////////////////////
   assign wr  = psel && penable && pwrite;
   assign rd  = psel && !penable && !pwrite;
   assign idx = paddr[5:2];
   assign wb  = pwdata[7:0];

   always_comb begin
      next_st   = st;
      arr_start = 1'b0;
      arr_abort = 1'b0;

      // register reads, latched on setup so prdata comes from flops
      if (rd) begin
         next_st.rdata = '0;
         unique case (idx)
            ecs_idx_divider: next_st.rdata[7:0] = {st.divider_loaded_flag, st.divider};
            ecs_idx_config:  next_st.rdata[7:6] = {st.buffer_empty_irq_enable,
                                                   st.complete_irq_enable};
            ecs_idx_protect: next_st.rdata[7:0] = st.protect;
            ecs_idx_status:  next_st.rdata[7:0] = {st.buffer_empty_flag,
                                st.command_complete_flag, st.protection_violation_flag,
                                st.access_error_flag, 1'b0, st.blank, 2'b00};
            ecs_idx_command: next_st.rdata[7:0] = st.stage.code & ecs_command_mask;
            // address read only in special mode
            ecs_idx_addr_high: if (st.special_mode)
               next_st.rdata[7:0] = {5'b00000, st.stage.addr[10:8]};
            ecs_idx_addr_low:  if (st.special_mode) next_st.rdata[7:0] = st.stage.addr[7:0];
            // data read only in special mode
            ecs_idx_data_high: if (st.special_mode) next_st.rdata[7:0] = st.stage.data[15:8];
            ecs_idx_data_low:  if (st.special_mode) next_st.rdata[7:0] = st.stage.data[7:0];
            ecs_idx_control: next_st.rdata[1:0] = {st.stop, st.special_mode};
            default: next_st.rdata = '0;
         endcase
      end

      // array completion and queue advance
      if (arr_done) begin
         next_st.blank = arr_blank;
         // second stage hands over the next job
         if (st.pending) begin
            arr_start       = 1'b1;
            next_st.pending = 1'b0;
         end else begin
            next_st.command_complete_flag = 1'b1;
         end
         // with a pending job the flag stays low
      end

      if (wr) begin
         unique case (idx)
            ecs_idx_divider: begin
               if (!st.divider_loaded_flag) begin
                  next_st.divider             = wb[6:0] & ecs_divider_mask[6:0];
                  next_st.divider_loaded_flag = 1'b1;
               end
            end
            ecs_idx_config: begin
               next_st.buffer_empty_irq_enable = wb[ecs_bit_be_irq_enable];
               next_st.complete_irq_enable     = wb[ecs_bit_cc_irq_enable];
            end
            // protection bits can only move toward protected
            ecs_idx_protect: next_st.protect = {st.protect[7] & wb[7], st.protect[6:4],
                                  st.protect[3] & wb[3],
                                  st.protect[3] ? wb[2:0] : st.protect[2:0]};
            ecs_idx_status: begin
               if (wb[ecs_bit_violation]) next_st.protection_violation_flag = 1'b0;
               if (wb[ecs_bit_access_error]) next_st.access_error_flag = 1'b0;
               if (wb[ecs_bit_buffer_empty]) begin
                  // write one clears buffer empty and launches
                  // locked while an error flag is set
                  if (st.seq == ecs_seq_have_cmd && st.buffer_empty_flag
                      && !st.protection_violation_flag && !st.access_error_flag) begin
                     next_st.buffer_empty_flag     = 1'b0;
                     next_st.command_complete_flag = 1'b0;
                     next_st.blank                 = 1'b0;
                     next_st.queued                = st.stage;
                     next_st.pending               = 1'b1;
                     next_st.seq                   = ecs_seq_idle;
                  end else if (st.seq != ecs_seq_idle) begin
                     next_st.access_error_flag = 1'b1;
                     next_st.seq               = ecs_seq_idle;
                  end
               end else if (st.seq != ecs_seq_idle) begin
                  next_st.access_error_flag = 1'b1;
                  next_st.seq               = ecs_seq_idle;
               end
            end
            ecs_idx_command: begin
               if (st.seq != ecs_seq_have_word) begin
                  next_st.access_error_flag = 1'b1;
                  next_st.seq               = ecs_seq_idle;
               end else if (!legal_code(wb)) begin
                  next_st.access_error_flag = 1'b1;
                  next_st.seq               = ecs_seq_idle;
               end else if (is_protected(st.protect, st.stage.addr, wb)) begin
                  next_st.protection_violation_flag = 1'b1;
                  next_st.seq                       = ecs_seq_idle;
               end else begin
                  next_st.stage.code = wb;
                  if (wb == ecs_cmd_sector_erase) next_st.stage.addr[1:0] = 2'b00;
                  next_st.seq = ecs_seq_have_cmd;
               end
            end
            ecs_idx_addr_high: if (st.special_mode)
               next_st.stage.addr[10:8] = wb[2:0] & ecs_addr_high_mask[2:0];
            ecs_idx_addr_low:  if (st.special_mode) next_st.stage.addr[7:0] = wb;
            ecs_idx_data_high: if (st.special_mode) next_st.stage.data[15:8] = wb;
            ecs_idx_data_low:  if (st.special_mode) next_st.stage.data[7:0] = wb;
            ecs_idx_array_addr: next_st.stage.addr = pwdata[10:0];
            ecs_idx_array_data: begin
               // word write only from an empty buffer, after divider load
               // no array write before divider loaded
               if (st.seq != ecs_seq_idle || !st.buffer_empty_flag
                   || !st.divider_loaded_flag || st.stage.addr[0]) begin
                  next_st.access_error_flag = 1'b1;
                  next_st.seq               = ecs_seq_idle;
               end else begin
                  next_st.stage.data = pwdata[15:0];
                  next_st.seq        = ecs_seq_have_word;
               end
            end
            ecs_idx_control: begin
               next_st.special_mode = wb[ecs_bit_special_mode];
               next_st.stop         = wb[ecs_bit_stop_request];
               // stop while running is an error
               if (wb[ecs_bit_stop_request] && !st.stop && !st.command_complete_flag) begin
                  arr_abort                     = 1'b1;
                  arr_start                     = 1'b0;
                  next_st.pending               = 1'b0;
                  next_st.command_complete_flag = 1'b1;
                  next_st.access_error_flag     = 1'b1;
               end
               // stop exit refills buffer, drops pending
               if (!wb[ecs_bit_stop_request] && st.stop) begin
                  next_st.buffer_empty_flag = 1'b1;
                  next_st.pending           = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // second stage empties into the array when it is free
      // buffer empty sets again once stage moves on
      if (st.pending && !arr_busy && !arr_done && !arr_abort && !st.stop) begin
         arr_start                 = 1'b1;
         next_st.pending           = 1'b0;
      end
      if (!next_st.pending && !next_st.buffer_empty_flag && !next_st.stop) begin
         next_st.buffer_empty_flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st                       <= '0;
         st.buffer_empty_flag     <= 1'b1;
         st.command_complete_flag <= 1'b1;
         st.protect               <= 8'hff;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign prdata  = st.rdata;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign buffer_empty_irq = st.buffer_empty_flag && st.buffer_empty_irq_enable;
   assign complete_irq     = st.command_complete_flag && st.complete_irq_enable;
endmodule : ecs_sequencer

/* File: tb/ecs_sequencer_chk.sv */
`timescale 1ns/1ns
module ecs_sequencer_chk
   import ecs_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [5:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        buffer_empty_irq,
   input wire logic        complete_irq
);
   logic [1:0] irq_en;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en <= 2'b00;
      end else if (psel && penable && pwrite && paddr[5:2] == ecs_idx_config) begin
         irq_en <= pwdata[7:6];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_read(logic [3:0] idx);
      psel && penable && !pwrite && paddr[5:2] == idx;
   endsequence
   a_ready_next: assert property (s_setup |=> pready) else $error("access phase stalled");
   a_no_error: assert property (psel && penable |-> !pslverr) else $error("error response");
   a_be_irq_rd: assert property (s_read(ecs_idx_status) |->
      (prdata[7] && $past(irq_en[1])) == $past(buffer_empty_irq)) else $error("empty irq wrong");
   a_cc_irq_rd: assert property (s_read(ecs_idx_status) |->
      (prdata[6] && $past(irq_en[0])) == $past(complete_irq)) else $error("complete irq wrong");
   a_be_irq_off: assert property (!irq_en[1] |-> !buffer_empty_irq) else $error("empty irq unmasked");
   a_cc_irq_off: assert property (!irq_en[0] |-> !complete_irq) else $error("done irq unmasked");
   a_status_zeros: assert property (s_read(ecs_idx_status) |->
      (prdata & 32'hffff_ff0b) == 32'h0000_0000) else $error("status zero bits set");
   a_cmd_zeros: assert property (s_read(ecs_idx_command) |->
      (prdata & 32'hffff_ff9a) == 32'h0000_0000) else $error("command zero bits set");
   a_addr_hi_zeros: assert property (s_read(ecs_idx_addr_high) |->
      (prdata & 32'hffff_fff8) == 32'h0000_0000) else $error("address high bits set");
endmodule : ecs_sequencer_chk

bind ecs_sequencer ecs_sequencer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .buffer_empty_irq, .complete_irq);

/* File: tb/ecs_host.sv */
`timescale 1ns/1ns
// cpu stand-in: one transfer at a time
module ecs_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [5:0]       paddr,
   output logic [31:0]      pwdata,
   output logic             stalled
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 6'h00;
      pwdata = 32'h0000_0000;
      stalled = 1'b0;
   end
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) stalled <= 1'b1;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   ////////////////////////////////////////////////////////////////////////
   // address, data and command writes, then the buffer empty write when go is set
   task automatic launch(input logic [10:0] a, input logic [15:0] d, input logic [7:0] c,
                         input logic go);
      logic [31:0] q;
      xfer(1'b1, 6'h30, {21'h00_0000, a}, q);
      xfer(1'b1, 6'h34, {16'h0000, d}, q);
      xfer(1'b1, 6'h18, {24'h00_0000, c}, q);
      if (go) xfer(1'b1, 6'h14, 32'h0000_0080, q);
   endtask : launch
endmodule : ecs_host

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import ecs_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [5:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        buffer_empty_irq;
   logic        complete_irq;
   logic        stalled;
   logic [31:0] q;
   int          miscompares;
   int          cmp_count;
   ecs_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .buffer_empty_irq, .complete_irq);
   ecs_host u_host (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata,
      .stalled);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, w, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      u_host.xfer(1'b1, {idx, 2'b00}, {24'h00_0000, d}, q);
   endtask : wr
   task automatic rc(input logic [3:0] idx, input logic [7:0] m, input logic [7:0] e,
                     input string w);
      u_host.xfer(1'b0, {idx, 2'b00}, 32'h0000_0000, q);
      chk(q & {24'h00_0000, m}, {24'h00_0000, e}, w);
   endtask : rc
   task automatic wait_cc();
      for (int n = 0; n < 100; n++) begin
         u_host.xfer(1'b0, {ecs_idx_status, 2'b00}, 32'h0000_0000, q);
         if (q[ecs_bit_complete] === 1'b1) return;
      end
      miscompares++;
      close_out();
   endtask : wait_cc
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   always @(posedge stalled) begin
      miscompares++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rc(ecs_idx_status, 8'hff, ecs_status_reset, "status reset");
      rc(ecs_idx_divider, 8'h80, 8'h00, "not loaded");
      wr(ecs_idx_array_addr, 8'h02);
      wr(ecs_idx_array_data, 8'h34);
      rc(ecs_idx_status, 8'h10, 8'h10, "no divider");
      wr(ecs_idx_status, 8'h00);
      rc(ecs_idx_status, 8'h10, 8'h10, "zero keeps");
      wr(ecs_idx_status, 8'h10);
      rc(ecs_idx_status, 8'hff, 8'hc0, "cleared");
      rc(4'hf, 8'hff, 8'h00, "unmapped");
      $display("test reset done");
   endtask : t_reset
   task automatic t_program();
      wr(ecs_idx_divider, 8'h03);
      rc(ecs_idx_divider, 8'h80, 8'h80, "loaded");
      wr(ecs_idx_config, 8'hc0);
      @(negedge pclk);
      chk({30'h0000_0000, buffer_empty_irq, complete_irq}, 32'h0000_0003, "irqs");
      u_host.launch(11'h002, 16'h1234, ecs_cmd_word_program, 1'b1);
      rc(ecs_idx_status, 8'hc0, 8'h80, "launched");
      @(negedge pclk);
      chk({31'h0000_0000, complete_irq}, 32'h0000_0000, "done irq low");
      wait_cc();
      rc(ecs_idx_status, 8'hff, 8'hc0, "program done");
      u_host.launch(11'h004, 16'h0011, ecs_cmd_word_program, 1'b1);
      u_host.launch(11'h006, 16'h0022, ecs_cmd_word_program, 1'b1);
      rc(ecs_idx_status, 8'hc0, 8'h00, "both full");
      repeat (3) rc(ecs_idx_status, 8'h40, 8'h00, "chained");
      wait_cc();
      rc(ecs_idx_status, 8'hff, 8'hc0, "chain done");
      $display("test program done");
   endtask : t_program
   task automatic t_codes();
      logic [7:0] codes [5] = '{ecs_cmd_word_program, ecs_cmd_sector_erase,
         ecs_cmd_sector_modify, ecs_cmd_mass_erase, ecs_cmd_erase_verify};
      foreach (codes[i]) begin
         u_host.launch(11'h010, 16'h00a5, codes[i], 1'b1);
         wait_cc();
         rc(ecs_idx_status, 8'h30, 8'h00, "legal");
      end
      rc(ecs_idx_status, 8'h04, 8'h04, "blank");
      u_host.launch(11'h010, 16'h00a5, 8'hff, 1'b0);
      rc(ecs_idx_status, 8'h10, 8'h10, "illegal");
      rc(ecs_idx_command, 8'h9a, 8'h00, "cmd zeros");
      wr(ecs_idx_status, 8'h10);
      u_host.launch(11'h012, 16'h005a, ecs_cmd_word_program, 1'b1);
      wait_cc();
      rc(ecs_idx_status, 8'hff, 8'hc0, "blank cleared");
      wr(ecs_idx_array_addr, 8'h20);
      wr(ecs_idx_array_data, 8'h55);
      wr(ecs_idx_status, 8'h00);
      rc(ecs_idx_status, 8'h90, 8'h90, "zero aborts");
      wr(ecs_idx_status, 8'h10);
      $display("test codes done");
   endtask : t_codes
   task automatic t_special();
      wr(ecs_idx_addr_high, 8'hff);
      rc(ecs_idx_addr_high, 8'hff, 8'h00, "addr locked");
      wr(ecs_idx_control, 8'h01);
      wr(ecs_idx_addr_high, 8'hff);
      rc(ecs_idx_addr_high, 8'hff, 8'h07, "address high");
      wr(ecs_idx_data_low, 8'ha5);
      rc(ecs_idx_data_low, 8'hff, 8'ha5, "data open");
      wr(ecs_idx_test_three, 8'hff);
      rc(ecs_idx_test_three, 8'hff, 8'h00, "reserved");
      wr(ecs_idx_control, 8'h00);
      rc(ecs_idx_data_low, 8'hff, 8'h00, "data hidden");
      u_host.launch(11'h030, 16'h0077, ecs_cmd_word_program, 1'b1);
      wr(ecs_idx_control, 8'h02);
      rc(ecs_idx_status, 8'h50, 8'h50, "stop aborts");
      wr(ecs_idx_control, 8'h00);
      rc(ecs_idx_status, 8'h80, 8'h80, "stop exit");
      wr(ecs_idx_status, 8'h10);
      // protection is one-way, so it runs last
      wr(ecs_idx_protect, 8'h7f);
      u_host.launch(11'h040, 16'h0001, ecs_cmd_word_program, 1'b0);
      rc(ecs_idx_status, 8'h20, 8'h20, "protected");
      wr(ecs_idx_status, 8'h00);
      rc(ecs_idx_status, 8'h20, 8'h20, "zero keeps");
      u_host.launch(11'h040, 16'h0001, ecs_cmd_word_program, 1'b1);
      rc(ecs_idx_status, 8'h40, 8'h40, "locked out");
      wr(ecs_idx_status, 8'h30);
      rc(ecs_idx_status, 8'h30, 8'h00, "cleared");
      $display("test special done");
   endtask : t_special
   initial begin
      presetn = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_program();
      t_codes();
      t_special();
      close_out();
   end
endmodule : testbench
